// >>> rtl/llpir_pkg.sv
package llpir_pkg;

    // Byte addresses of the registers on the system bus.
    localparam logic [31:0] GREEN_SHADE_TABLE_ADDR = 32'h4d00_0024;
    localparam logic [31:0] BLUE_SHADE_TABLE_ADDR = 32'h4d00_0028;
    localparam logic [31:0] DITHER_SETTING_ADDR = 32'h4d00_004c;
    localparam logic [31:0] PALETTE_OVERRIDE_ADDR = 32'h4d00_0050;
    localparam logic [31:0] IRQ_PENDING_ADDR = 32'h4d00_0054;
    localparam logic [31:0] IRQ_SOURCE_PENDING_ADDR = 32'h4d00_0058;
    localparam logic [31:0] IRQ_MASK_AND_LEVEL_ADDR = 32'h4d00_005c;

    // Window kept for factory test; any access there is answered with an error.
    localparam logic [31:0] TEST_AREA_FIRST_ADDR = 32'h4d00_002c;
    localparam logic [31:0] TEST_AREA_LAST_ADDR = 32'h4d00_0048;

    // Reset values.
    localparam logic [31:0] GREEN_SHADE_TABLE_RST = 32'h0000_0000;
    localparam logic [15:0] BLUE_SHADE_TABLE_RST = 16'h0000;
    localparam logic [18:0] DITHER_SETTING_RST = 19'h0_0000;
    localparam logic [24:0] PALETTE_OVERRIDE_RST = 25'h000_0000;
    localparam logic [1:0] IRQ_PENDING_RST = 2'h0;
    localparam logic [1:0] IRQ_SOURCE_PENDING_RST = 2'h0;
    localparam logic [1:0] IRQ_MASK_RST = 2'h3;
    localparam logic FIFO_THRESHOLD_SELECT_RST = 1'b0;

    // Field positions.
    localparam int PALETTE_OVERRIDE_ON_BIT = 24;
    localparam int FRAME_SYNC_IRQ_BIT = 1;
    localparam int FIFO_LEVEL_IRQ_BIT = 0;
    localparam int FIFO_THRESHOLD_SELECT_BIT = 2;

    // Pixel FIFO trigger levels in words.
    localparam logic [3:0] FIFO_THRESHOLD_LOW = 4'h4;
    localparam logic [3:0] FIFO_THRESHOLD_HIGH = 4'h8;

endpackage : llpir_pkg

// >>> rtl/llpir_regs.sv
`timescale 1ns/1ps
// Functional notes
// - Green code n picks the nibble at bits 4n+3..4n of the green table.
// - The blue table is a 16-bit field giving a shade for each 2-bit code.
// - Blue codes 00,01,10,11 pick bits 3:0, 7:4, 11:8 and 15:12.
// - With the override enabled, the next frame shows the override colour.
// - The override colour holds red, green and blue from high byte to low.
// - A frame-sync event sets source pending bit 1 whatever the mask.
// - Reaching the FIFO trigger level sets source pending bit 0.
// - The pending register shows the unmasked requests passed on.
// - A mask bit of one blocks its source; both mask bits reset to one.
// - The threshold select bit picks four words when clear, eight when set.
// - Pending bits and the override enable reset to zero.
module llpir_regs (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pixel path.
    input wire logic [2:0] green_code,
    input wire logic [1:0] blue_code,
    input wire logic [23:0] pixel_rgb,
    input wire logic frame_start,
    output logic [3:0] green_shade,
    output logic [3:0] blue_shade,
    output logic [23:0] video_data,
    output logic [18:0] dither_mode,
    // Interrupt sources and output.
    input wire logic frame_sync_event,
    input wire logic [3:0] fifo_level_words,
    output logic irq
);

    logic [31:0] green_shade_field_reg;
    logic [15:0] blue_shade_field_reg;
    logic [18:0] dither_setting_reg;
    logic palette_override_on_reg;
    logic [23:0] palette_override_colour_reg;
    logic [1:0] irq_pending_reg;
    logic [1:0] irq_source_pending_reg;
    logic [1:0] irq_mask_reg;
    logic fifo_threshold_select_reg;
    logic override_active_reg;
    logic [23:0] override_colour_reg;
    logic fifo_hit_prev_reg;
    logic [3:0] green_shade_reg;
    logic [3:0] blue_shade_reg;
    logic [23:0] video_data_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    logic setup_phase;
    logic wr_take;
    logic in_test_area;
    logic addr_mapped;
    logic [31:0] read_mux;
    logic [3:0] fifo_threshold;
    logic fifo_hit;
    logic [1:0] events;
    logic [1:0] src_clear;
    logic [1:0] pnd_clear;

    // Bus phase decode; a write lands on the single access cycle.
    assign setup_phase = psel && !penable;
    assign wr_take = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign in_test_area = (paddr >= llpir_pkg::TEST_AREA_FIRST_ADDR) &&
                          (paddr <= llpir_pkg::TEST_AREA_LAST_ADDR);

    // Read data and address map.
    always_comb begin
        addr_mapped = 1'b1;
        read_mux = 32'h0000_0000;
        unique case (paddr)
            llpir_pkg::GREEN_SHADE_TABLE_ADDR: begin
                read_mux = green_shade_field_reg;
            end
            llpir_pkg::BLUE_SHADE_TABLE_ADDR: begin
                read_mux = {16'h0000, blue_shade_field_reg};
            end
            llpir_pkg::DITHER_SETTING_ADDR: begin
                read_mux = {13'h0000, dither_setting_reg};
            end
            llpir_pkg::PALETTE_OVERRIDE_ADDR: begin
                read_mux = {7'h00, palette_override_on_reg,
                            palette_override_colour_reg};
            end
            llpir_pkg::IRQ_PENDING_ADDR: begin
                read_mux = {30'h0000_0000, irq_pending_reg};
            end
            llpir_pkg::IRQ_SOURCE_PENDING_ADDR: begin
                read_mux = {30'h0000_0000, irq_source_pending_reg};
            end
            llpir_pkg::IRQ_MASK_AND_LEVEL_ADDR: begin
                read_mux = {29'h0000_0000, fifo_threshold_select_reg,
                            irq_mask_reg};
            end
            default: begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    // One wait-free access cycle follows each setup cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup_phase;
            if (setup_phase) begin
                pslverr_reg <= !addr_mapped || in_test_area;
                prdata_reg <= (pwrite || !addr_mapped) ? 32'h0000_0000
                                                       : read_mux;
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            green_shade_field_reg <= llpir_pkg::GREEN_SHADE_TABLE_RST;
            blue_shade_field_reg <= llpir_pkg::BLUE_SHADE_TABLE_RST;
            dither_setting_reg <= llpir_pkg::DITHER_SETTING_RST;
            palette_override_on_reg <=
                llpir_pkg::PALETTE_OVERRIDE_RST[24];
            palette_override_colour_reg <=
                llpir_pkg::PALETTE_OVERRIDE_RST[23:0];
            irq_mask_reg <= llpir_pkg::IRQ_MASK_RST;
            fifo_threshold_select_reg <= llpir_pkg::FIFO_THRESHOLD_SELECT_RST;
        end else if (wr_take) begin
            unique case (paddr)
                llpir_pkg::GREEN_SHADE_TABLE_ADDR: begin
                    green_shade_field_reg <= pwdata;
                end
                llpir_pkg::BLUE_SHADE_TABLE_ADDR: begin
                    blue_shade_field_reg <= pwdata[15:0];
                end
                llpir_pkg::DITHER_SETTING_ADDR: begin
                    // Stored as written; only two values are meaningful.
                    dither_setting_reg <= pwdata[18:0];
                end
                llpir_pkg::PALETTE_OVERRIDE_ADDR: begin
                    palette_override_on_reg <=
                        pwdata[llpir_pkg::PALETTE_OVERRIDE_ON_BIT];
                    palette_override_colour_reg <= pwdata[23:0];
                end
                llpir_pkg::IRQ_MASK_AND_LEVEL_ADDR: begin
                    irq_mask_reg <= pwdata[1:0];
                    fifo_threshold_select_reg <=
                        pwdata[llpir_pkg::FIFO_THRESHOLD_SELECT_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Shade lookup for passive panels.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            green_shade_reg <= 4'h0;
            blue_shade_reg <= 4'h0;
        end else begin
            green_shade_reg <=
                green_shade_field_reg[{green_code, 2'b00} +: 4];
            blue_shade_reg <=
                blue_shade_field_reg[{blue_code, 2'b00} +: 4];
        end
    end

    // The override is sampled at frame start so it covers a whole frame.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            override_active_reg <= 1'b0;
            override_colour_reg <= 24'h00_0000;
            video_data_reg <= 24'h00_0000;
        end else begin
            if (frame_start) begin
                override_active_reg <= palette_override_on_reg;
                override_colour_reg <= palette_override_colour_reg;
            end
            video_data_reg <= override_active_reg ? override_colour_reg
                                                  : pixel_rgb;
        end
    end

    // FIFO trigger detection on the rising crossing of the threshold.
    assign fifo_threshold = fifo_threshold_select_reg ?
                            llpir_pkg::FIFO_THRESHOLD_HIGH :
                            llpir_pkg::FIFO_THRESHOLD_LOW;
    assign fifo_hit = fifo_level_words >= fifo_threshold;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_hit_prev_reg <= 1'b0;
        end else begin
            fifo_hit_prev_reg <= fifo_hit;
        end
    end

    // Interrupt events and write-one-to-clear strobes.
    assign events = {frame_sync_event, fifo_hit && !fifo_hit_prev_reg};
    assign src_clear = (wr_take &&
                        paddr == llpir_pkg::IRQ_SOURCE_PENDING_ADDR) ?
                       pwdata[1:0] : 2'b00;
    assign pnd_clear = (wr_take && paddr == llpir_pkg::IRQ_PENDING_ADDR) ?
                       pwdata[1:0] : 2'b00;

    // Sticky pending bits; a new event wins over a clear in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_source_pending_reg <=
                llpir_pkg::IRQ_SOURCE_PENDING_RST;
            irq_pending_reg <= llpir_pkg::IRQ_PENDING_RST;
        end else begin
            irq_source_pending_reg <= (irq_source_pending_reg & ~src_clear) |
                                      events;
            irq_pending_reg <= (irq_pending_reg & ~pnd_clear) |
                               ((events | irq_source_pending_reg) &
                                ~irq_mask_reg);
        end
    end

    // Level interrupt while any unmasked request is pending.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |irq_pending_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign green_shade = green_shade_reg;
    assign blue_shade = blue_shade_reg;
    assign video_data = video_data_reg;
    assign dither_mode = dither_setting_reg;
    assign irq = irq_reg;

    chk_green_nibble: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (green_code == 3'h5) |=>
            green_shade == $past(green_shade_field_reg[23:20]))
        else $error("Green code five did not pick bits 23:20.");

    chk_blue_nibble: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (blue_code == 2'h2) |=>
            blue_shade == $past(blue_shade_field_reg[11:8]))
        else $error("Blue code two did not pick bits 11:8.");

    chk_override_next_frame: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (frame_start && palette_override_on_reg) ##1 !frame_start |=>
            video_data == $past(override_colour_reg))
        else $error("Override colour not shown after frame start.");

    chk_frame_src_set: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        frame_sync_event |=> irq_source_pending_reg[1])
        else $error("Frame event did not set source pending bit 1.");

    chk_fifo_four_words: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (!fifo_threshold_select_reg && fifo_level_words == 4'h3) ##1
        (!fifo_threshold_select_reg && fifo_level_words == 4'h4) |=>
            irq_source_pending_reg[0])
        else $error("FIFO event missed at four words.");

    chk_fifo_eight_words: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (fifo_threshold_select_reg && fifo_level_words < 4'h8) ##1
        (fifo_threshold_select_reg && fifo_level_words == 4'h8) |=>
            irq_source_pending_reg[0])
        else $error("FIFO event missed at eight words.");

    chk_masked_no_pend: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_mask_reg == 2'h3 && irq_pending_reg == 2'h0) |=>
            irq_pending_reg == 2'h0)
        else $error("Masked source reached the pending register.");

    chk_pend_to_irq: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (frame_sync_event && !irq_mask_reg[1]) |=>
            irq_pending_reg[1] ##1 irq)
        else $error("Unmasked frame event did not raise the interrupt.");

    chk_w1c_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (src_clear[1] && !frame_sync_event) |=> !irq_source_pending_reg[1])
        else $error("Writing one did not clear source pending bit 1.");

    chk_blue_field_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_take && paddr == llpir_pkg::BLUE_SHADE_TABLE_ADDR) |=>
            blue_shade_field_reg == $past(pwdata[15:0]))
        else $error("Blue table did not keep the low half of the write.");

    chk_palette_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_take && paddr == llpir_pkg::PALETTE_OVERRIDE_ADDR) |=>
            palette_override_colour_reg == $past(pwdata[23:0]))
        else $error("Override colour bytes were not stored as written.");

    chk_irq_follows_pend: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_pending_reg != 2'h0) |=> irq)
        else $error("Pending request did not raise the interrupt.");

    chk_irq_quiet: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (irq_pending_reg == 2'h0) |=> !irq)
        else $error("Interrupt raised with nothing pending.");

    chk_fifo_below_eight: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (fifo_threshold_select_reg && fifo_level_words < 4'h8 &&
         !irq_source_pending_reg[llpir_pkg::FIFO_LEVEL_IRQ_BIT]) |=>
            !irq_source_pending_reg[llpir_pkg::FIFO_LEVEL_IRQ_BIT])
        else $error("FIFO event taken below eight words.");

    chk_fifo_src_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (src_clear[0] && !(fifo_hit && !fifo_hit_prev_reg)) |=>
            !irq_source_pending_reg[llpir_pkg::FIFO_LEVEL_IRQ_BIT])
        else $error("Writing one did not clear source pending bit 0.");

endmodule : llpir_regs

// >>> bench/llpir_regs_tb.sv
`timescale 1ns/1ps
module llpir_regs_tb;
    // Short local aliases of the register addresses.
    localparam logic [31:0] A_GRN = llpir_pkg::GREEN_SHADE_TABLE_ADDR;
    localparam logic [31:0] A_BLU = llpir_pkg::BLUE_SHADE_TABLE_ADDR;
    localparam logic [31:0] A_DTH = llpir_pkg::DITHER_SETTING_ADDR;
    localparam logic [31:0] A_PAL = llpir_pkg::PALETTE_OVERRIDE_ADDR;
    localparam logic [31:0] A_PND = llpir_pkg::IRQ_PENDING_ADDR;
    localparam logic [31:0] A_SRC = llpir_pkg::IRQ_SOURCE_PENDING_ADDR;
    localparam logic [31:0] A_MSK = llpir_pkg::IRQ_MASK_AND_LEVEL_ADDR;
    localparam logic [31:0] GTAB = 32'hfedc_ba98;
    localparam logic [31:0] BTAB = 32'h0000_5a3c;

    // Stimulus and observed signals.
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] green_code = 3'h0;
    logic [1:0] blue_code = 2'h0;
    logic [23:0] pixel_rgb = 24'h0;
    logic frame_start = 1'b0;
    logic [3:0] green_shade;
    logic [3:0] blue_shade;
    logic [23:0] video_data;
    logic [18:0] dither_mode;
    logic frame_sync_event = 1'b0;
    logic [3:0] fifo_level_words = 4'h0;
    logic irq;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;

    // Device under test.
    llpir_regs u_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .green_code, .blue_code,
        .pixel_rgb, .frame_start, .green_shade, .blue_shade, .video_data,
        .dither_mode, .frame_sync_event, .fifo_level_words, .irq);

    // Free-running clock at 100 MHz.
    always #5 ref_clk = ~ref_clk;

    // Cuts a hung run short; the tests need well under 2000 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            $display("BAD %0t run timed out", $time);
            results();
        end
    end

    // Compares a value with its expectation and counts the result.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; waits for pready and keeps data and error flag.
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // Reads a register and checks both its data and its error response.
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp,
                        input logic experr);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, experr});
    endtask : rchk

    // Lets a number of clock edges pass.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    // Drives a one-cycle pulse on the frame start or frame sync input.
    task automatic pulse(input logic sync);
        @(posedge ref_clk);
        if (sync) frame_sync_event <= 1'b1;
        else frame_start <= 1'b1;
        @(posedge ref_clk);
        frame_sync_event <= 1'b0;
        frame_start <= 1'b0;
        tick(3);
    endtask : pulse

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // Main test sequence.
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rchk(A_GRN, 32'h0, 1'b0);
        rchk(A_BLU, 32'h0, 1'b0);
        rchk(A_PAL, 32'h0, 1'b0);
        rchk(A_PND, 32'h0, 1'b0);
        rchk(A_SRC, 32'h0, 1'b0);
        rchk(A_MSK, 32'h3, 1'b0);
        chk({31'h0, irq}, 32'h0);
        $display("test reset values ended");
        xfer(1'b1, A_GRN, GTAB);
        xfer(1'b1, A_BLU, 32'hffff_5a3c);
        rchk(A_BLU, BTAB, 1'b0);
        for (int n = 0; n < 8; n++) begin
            green_code <= 3'(n);
            blue_code <= 2'(n);
            tick(3);
            chk({28'h0, green_shade}, (GTAB >> (4 * n)) & 32'hf);
            chk({28'h0, blue_shade}, (BTAB >> (4 * (n % 4))) & 32'hf);
        end
        xfer(1'b1, A_DTH, 32'h0001_2210);
        rchk(A_DTH, 32'h0001_2210, 1'b0);
        chk({13'h0, dither_mode}, 32'h0001_2210);
        $display("test lookup and dither ended");
        pixel_rgb <= 24'h12_3456;
        xfer(1'b1, A_PAL, 32'h01a1_b2c3);
        rchk(A_PAL, 32'h01a1_b2c3, 1'b0);
        tick(2);
        chk({8'h0, video_data}, 32'h0012_3456);
        pulse(1'b0);
        chk({8'h0, video_data}, 32'h00a1_b2c3);
        xfer(1'b1, A_PAL, 32'h0);
        pulse(1'b0);
        chk({8'h0, video_data}, 32'h0012_3456);
        $display("test palette override ended");
        pulse(1'b1);
        rchk(A_SRC, 32'h2, 1'b0);
        rchk(A_PND, 32'h0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, A_SRC, 32'h0);
        rchk(A_SRC, 32'h2, 1'b0);
        xfer(1'b1, A_SRC, 32'h2);
        rchk(A_SRC, 32'h0, 1'b0);
        xfer(1'b1, A_MSK, 32'h1);
        pulse(1'b1);
        rchk(A_PND, 32'h2, 1'b0);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, A_SRC, 32'h2);
        xfer(1'b1, A_PND, 32'h2);
        rchk(A_PND, 32'h0, 1'b0);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        $display("test frame sync interrupt ended");
        xfer(1'b1, A_MSK, 32'h0);
        fifo_level_words <= 4'h3;
        tick(3);
        rchk(A_SRC, 32'h0, 1'b0);
        fifo_level_words <= 4'h4;
        tick(3);
        rchk(A_SRC, 32'h1, 1'b0);
        rchk(A_PND, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h1);
        fifo_level_words <= 4'h0;
        xfer(1'b1, A_SRC, 32'h1);
        xfer(1'b1, A_PND, 32'h1);
        xfer(1'b1, A_MSK, 32'h4);
        rchk(A_MSK, 32'h4, 1'b0);
        fifo_level_words <= 4'h4;
        tick(3);
        rchk(A_SRC, 32'h0, 1'b0);
        fifo_level_words <= 4'h8;
        tick(3);
        rchk(A_SRC, 32'h1, 1'b0);
        $display("test fifo interrupt ended");
        xfer(1'b1, 32'h4d00_0040, 32'hffff_ffff);
        chk({31'h0, er}, 32'h1);
        rchk(32'h4d00_002c, 32'h0, 1'b1);
        rchk(32'h4d00_0060, 32'h0, 1'b1);
        rchk(A_GRN, GTAB, 1'b0);
        $display("test refused addresses ended");
        // Second reset with pending bits and the override enable set.
        xfer(1'b1, A_PAL, 32'h0100_0000);
        fifo_level_words <= 4'h0;
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        rchk(A_PAL, 32'h0, 1'b0);
        rchk(A_PND, 32'h0, 1'b0);
        rchk(A_SRC, 32'h0, 1'b0);
        rchk(A_MSK, 32'h3, 1'b0);
        chk({31'h0, irq}, 32'h0);
        $display("test second reset ended");
        results();
    end
endmodule : llpir_regs_tb
